// [ctd_pkg.sv]
package ctd_pkg;
  localparam int unsigned CTD_DATA_W      = 32;
  localparam int unsigned CTD_TAG_W       = 3;
  localparam int unsigned CTD_FIFO_DEPTH  = 4;
  localparam int unsigned CTD_PEND_W      = 4;
  localparam logic [2:0]  CTD_TAG_OLDEST  = 3'h0;
  localparam logic [2:0]  CTD_TAG_YOUNGEST = 3'h7;
  localparam logic [3:0]  CTD_PEND_RST    = 4'h0;
  localparam logic [3:0]  CTD_PEND_ONE    = 4'h1;
  localparam logic [31:0] CTD_WORD_RST    = 32'h0000_0000;
  typedef logic [CTD_DATA_W-1:0] ctd_word_t;
  typedef logic [CTD_TAG_W-1:0]  ctd_tag_t;
  typedef logic [CTD_PEND_W-1:0] ctd_pend_t;
endpackage : ctd_pkg

// [ctd_fifo.sv]
`timescale 1ns/100ps
`default_nettype none

module ctd_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic             ready_ff;
  logic             valid_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [CW-1:0]    nxt_count;
  logic             push;
  logic             pop;

  assign in_ready  = ready_ff;
  assign out_valid = valid_ff;
  assign out_data  = mem[rd_ptr_ff];

  // Flags are registered from the next count so both sides see honest
  // full and empty without a combinational path through the counter.
  always_comb begin
    push       = in_valid && ready_ff;
    pop        = out_ready && valid_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_count  = count_ff;
    if (push) begin
      nxt_wr_ptr = (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + AW'(1);
    end
    if (pop) begin
      nxt_rd_ptr = (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + AW'(1);
    end
    if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b0;
      valid_ff  <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
      ready_ff  <= (nxt_count != FULL_CNT);
      valid_ff  <= (nxt_count != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule : ctd_fifo

`default_nettype wire

// [ctd_top.sv]
`timescale 1ns/100ps
`default_nettype none

module ctd_top (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                mtc_issue,
  input  wire logic                mtc_data_valid,
  input  wire ctd_pkg::ctd_word_t  mtc_data,
  output var  logic                mtc_data_ready,
  input  wire logic                to_cop_data_hold,
  input  wire ctd_pkg::ctd_tag_t   to_cop_reorder_limit,
  output var  logic                to_cop_data_strobe,
  output var  ctd_pkg::ctd_word_t  to_cop_data_word,
  output var  ctd_pkg::ctd_tag_t   to_cop_order_tag
);
  import ctd_pkg::*;

  logic       fifo_valid;
  ctd_word_t  fifo_data;
  logic       pop;
  ctd_pend_t  pend_ff;
  ctd_pend_t  nxt_pend;
  logic       strobe_ff;
  logic       nxt_strobe;
  ctd_word_t  word_ff;
  ctd_word_t  nxt_word;
  ctd_tag_t   tag_ff;
  ctd_tag_t   nxt_tag;
  ctd_tag_t   limit_unused;

  // The limit only bounds reordering, which this path never does.
  assign limit_unused = to_cop_reorder_limit;

  // The buffer's ready is registered inside it, so the core sees a flop.
  ctd_fifo #(
    .WIDTH (CTD_DATA_W),
    .DEPTH (CTD_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (mtc_data_valid),
    .in_ready  (mtc_data_ready),
    .in_data   (mtc_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // A word leaves only when a move is outstanding, so a word that arrives
  // before its instruction is dispatched waits in the buffer.
  always_comb begin
    pop        = fifo_valid && (pend_ff != CTD_PEND_RST)
                 && !to_cop_data_hold;
    nxt_strobe = pop;
    nxt_word   = pop ? fifo_data : word_ff;
    nxt_tag    = CTD_TAG_OLDEST;
    nxt_pend   = pend_ff;
    if (mtc_issue && !pop) begin
      nxt_pend = pend_ff + CTD_PEND_ONE;
    end else if (pop && !mtc_issue) begin
      nxt_pend = pend_ff - CTD_PEND_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_ff   <= CTD_PEND_RST;
      strobe_ff <= 1'b0;
      word_ff   <= CTD_WORD_RST;
      tag_ff    <= CTD_TAG_OLDEST;
    end else begin
      pend_ff   <= nxt_pend;
      strobe_ff <= nxt_strobe;
      word_ff   <= nxt_word;
      tag_ff    <= nxt_tag;
    end
  end

  assign to_cop_data_strobe = strobe_ff;
  assign to_cop_data_word   = word_ff;
  assign to_cop_order_tag   = tag_ff;

  // Pop-side and dispatch conditions, shared by the delivery and count checks below.
  sequence s_send_ready;
    fifo_valid && (pend_ff != CTD_PEND_RST) && !to_cop_data_hold;
  endsequence

  sequence s_word_out(ctd_word_t w);
    strobe_ff && (word_ff == w);
  endsequence

  sequence s_dispatch;
    mtc_issue && !pop;
  endsequence

  sequence s_retire;
    pop && !mtc_issue;
  endsequence

  property p_strobe_cause;
    @(posedge clk) disable iff (!rst_n)
      strobe_ff |-> $past(fifo_valid) && ($past(pend_ff) != CTD_PEND_RST)
                    && !$past(to_cop_data_hold);
  endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("Strobe raised without a pending move and a buffered word.");

  property p_strobe_follows;
    @(posedge clk) disable iff (!rst_n)
      s_send_ready |=> strobe_ff;
  endproperty
  a_strobe_follows: assert property (p_strobe_follows)
    else $error("Ready word for a pending move was not strobed out.");

  property p_word_delivered;
    @(posedge clk) disable iff (!rst_n)
      s_send_ready |=> s_word_out($past(fifo_data));
  endproperty
  a_word_delivered: assert property (p_word_delivered)
    else $error("Strobed word differs from the buffered word.");

  property p_word_holds;
    @(posedge clk) disable iff (!rst_n)
      !strobe_ff && $past(!strobe_ff) |-> $stable(word_ff);
  endproperty
  a_word_holds: assert property (p_word_holds)
    else $error("Data word changed while no word was being sent.");

  property p_tag_oldest;
    @(posedge clk) disable iff (!rst_n)
      strobe_ff |-> (tag_ff == CTD_TAG_OLDEST) && (tag_ff <= CTD_TAG_YOUNGEST);
  endproperty
  a_tag_oldest: assert property (p_tag_oldest)
    else $error("Order tag with a word is not the oldest.");

  property p_tag_tied;
    @(posedge clk) disable iff (!rst_n)
      $changed(to_cop_reorder_limit) |=> (tag_ff == CTD_TAG_OLDEST)[*2];
  endproperty
  a_tag_tied: assert property (p_tag_tied)
    else $error("Order tag moved off zero.");

  property p_pend_count;
    @(posedge clk) disable iff (!rst_n)
      s_dispatch |=> pend_ff == $past(pend_ff) + CTD_PEND_ONE;
  endproperty
  a_pend_count: assert property (p_pend_count)
    else $error("Outstanding move count did not rise on dispatch.");

  property p_idle_no_strobe;
    @(posedge clk) disable iff (!rst_n)
      (pend_ff == CTD_PEND_RST) ##1 (pend_ff == CTD_PEND_RST) |-> !strobe_ff;
  endproperty
  a_idle_no_strobe: assert property (p_idle_no_strobe)
    else $error("Strobe raised with no outstanding move.");

  // A stall is seen in the pop cycle, so it shows as a missing strobe one
  // cycle later rather than as a dropped word.
  property p_hold_blocks;
    @(posedge clk) disable iff (!rst_n)
      to_cop_data_hold |=> !strobe_ff;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks)
    else $error("Word strobed out while the coprocessor was holding.");

  property p_empty_no_strobe;
    @(posedge clk) disable iff (!rst_n)
      !fifo_valid |=> !strobe_ff;
  endproperty
  a_empty_no_strobe: assert property (p_empty_no_strobe)
    else $error("Strobe raised with nothing buffered.");

  property p_early_word_waits;
    @(posedge clk) disable iff (!rst_n)
      fifo_valid && (pend_ff == CTD_PEND_RST) |=> !strobe_ff;
  endproperty
  a_early_word_waits: assert property (p_early_word_waits)
    else $error("Word left before its move was dispatched.");

  // Strobes may follow each other every cycle; a bubble here would halve
  // the rate the coprocessor can count on.
  property p_back_to_back;
    @(posedge clk) disable iff (!rst_n)
      s_send_ready ##1 s_send_ready |-> strobe_ff ##1 strobe_ff;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("Consecutive ready words were not strobed back to back.");

  property p_word_on_strobe;
    @(posedge clk) disable iff (!rst_n)
      $changed(word_ff) |-> strobe_ff;
  endproperty
  a_word_on_strobe: assert property (p_word_on_strobe)
    else $error("Data word changed without a strobe.");

  // The count has no overflow guard; the core keeps at most eight moves
  // outstanding, well inside its four-bit range.
  property p_pend_drop;
    @(posedge clk) disable iff (!rst_n)
      s_retire |=> pend_ff == $past(pend_ff) - CTD_PEND_ONE;
  endproperty
  a_pend_drop: assert property (p_pend_drop)
    else $error("Outstanding move count did not fall on delivery.");

  property p_pend_steady;
    @(posedge clk) disable iff (!rst_n)
      mtc_issue && pop |=> $stable(pend_ff);
  endproperty
  a_pend_steady: assert property (p_pend_steady)
    else $error("Outstanding move count moved when dispatch met delivery.");

  property p_full_stays_full;
    @(posedge clk) disable iff (!rst_n)
      !mtc_data_ready && fifo_valid && to_cop_data_hold |=> !mtc_data_ready;
  endproperty
  a_full_stays_full: assert property (p_full_stays_full)
    else $error("Buffer freed a slot while the coprocessor was holding.");
endmodule : ctd_top

`default_nettype wire

// [ctd_cop_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Coprocessor stand-in: stalls on demand or at random, counts what it takes.
module ctd_cop_model (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               stall,
  input  wire logic               slow,
  input  wire logic               to_cop_data_strobe,
  input  wire ctd_pkg::ctd_word_t to_cop_data_word,
  output var  logic               to_cop_data_hold,
  output var  ctd_pkg::ctd_tag_t  to_cop_reorder_limit
);
  import ctd_pkg::*;
  int unsigned rx_count = 0;
  ctd_word_t   rx_last  = CTD_WORD_RST;
  initial to_cop_data_hold = 1'b0;
  initial to_cop_reorder_limit = CTD_TAG_YOUNGEST;
  always @(posedge clk) begin
    // The limit moves only under reset, so it is static in operation.
    if (!rst_n) begin
      to_cop_reorder_limit <= ctd_tag_t'($urandom);
    end
    to_cop_data_hold <= stall | (slow & 1'($urandom_range(1)));
    if (rst_n && to_cop_data_strobe) begin
      rx_count <= rx_count + 1;
      rx_last  <= to_cop_data_word;
    end
  end
endmodule : ctd_cop_model

`default_nettype wire

// [ctd_top_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module ctd_top_tb_top;
  import ctd_pkg::*;
  logic      clk = 1'b0, rst_n = 1'b0, issue = 1'b0, dvalid = 1'b0;
  logic      stall = 1'b0, slow = 1'b0, seen_rst = 1'b0;
  logic      rdy, strobe, hold;
  ctd_word_t din = CTD_WORD_RST;
  ctd_word_t word;
  ctd_tag_t  tag, lim;
  int        err_count = 0, cmp_count = 0, pend = 0, acc = 0, n;
  int        avail = 0, owed = 0, sent = 0;
  bit        exp_stb = 1'b0, live = 1'b0;
  ctd_word_t last_exp = CTD_WORD_RST;
  ctd_word_t exp_q[$];
  always #20 clk = ~clk;
  ctd_top dut (.clk(clk), .rst_n(rst_n), .mtc_issue(issue),
    .mtc_data_valid(dvalid), .mtc_data(din), .mtc_data_ready(rdy),
    .to_cop_data_hold(hold), .to_cop_reorder_limit(lim),
    .to_cop_data_strobe(strobe), .to_cop_data_word(word),
    .to_cop_order_tag(tag));
  ctd_cop_model cop (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow),
    .to_cop_data_strobe(strobe), .to_cop_data_word(word),
    .to_cop_data_hold(hold), .to_cop_reorder_limit(lim));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  // Reference model: moves awaiting data and accepted words, oldest first.
  always @(posedge clk) begin
    if (!rst_n) begin
      if (seen_rst) check(strobe, 1'b0);
      seen_rst = 1'b1;
      pend = 0;
      acc = 0;
      avail = 0;
      owed = 0;
      exp_stb = 1'b0;
      live = 1'b0;
      exp_q.delete();
    end else begin
      check(tag, CTD_TAG_OLDEST);
      check(strobe, exp_stb);
      check(rdy, live && avail != CTD_FIFO_DEPTH);
      if (strobe === 1'b1) begin
        check(pend > 0 && exp_q.size() > 0, 1'b1);
        if (exp_q.size() > 0) begin
          last_exp = exp_q.pop_front();
          check(word, last_exp);
        end
        check(tag <= lim, 1'b1);
        check(tag, CTD_TAG_OLDEST);
        pend--;
        sent++;
      end
      // A word leaves when a buffered word meets a pending move with no
      // hold, and shows as a strobe at the following edge.
      exp_stb = avail > 0 && owed > 0 && hold === 1'b0;
      if (dvalid && rdy) avail++;
      if (issue) owed++;
      if (exp_stb) begin
        avail--;
        owed--;
      end
      live = 1'b1;
      if (issue) pend++;
      if (dvalid && rdy) begin
        exp_q.push_back(din);
        acc++;
      end
    end
  end
  // An offer not yet taken is held unchanged until the edge that takes it.
  task automatic step(input int cyc, input bit data, input bit iss);
    repeat (cyc) begin
      @(posedge clk);
      issue <= iss && pend < 6 && $urandom_range(1);
      if (!(dvalid && !rdy)) begin
        dvalid <= data && $urandom_range(1);
        din <= $urandom;
      end
    end
  endtask : step
  task automatic drain();
    for (n = 0; n < 400 && (exp_q.size() > 0 || dvalid); n++) step(1, 0, 1);
    if (n == 400) begin
      err_count++;
      conclude();
    end
  endtask : drain
  initial begin
    void'($urandom(59377));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    stall <= 1'b1;
    issue <= 1'b1;
    dvalid <= 1'b1;
    din <= $urandom;
    // Stalled far side: the buffer must refuse after exactly its depth.
    for (n = 0; n < 30 && !(acc == CTD_FIFO_DEPTH && !rdy); n++) begin
      @(posedge clk);
      issue <= 1'b0;
      if (dvalid && rdy) din <= $urandom;
    end
    check(acc, CTD_FIFO_DEPTH);
    check(cop.rx_count, 0);
    stall <= 1'b0;
    drain();
    step(400, 1, 1);
    slow <= 1'b1;
    step(400, 1, 1);
    drain();
    // Second reset picks a new limit; behaviour must not change with it.
    rst_n <= 1'b0;
    step(2, 0, 0);
    rst_n <= 1'b1;
    step(400, 1, 1);
    drain();
    repeat (2) @(posedge clk);
    check(cop.rx_count, sent);
    check(cop.rx_last, last_exp);
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule : ctd_top_tb_top

`default_nettype wire
